// >>> inc/cex_consts.svh
// Register indices, field positions and reset values of the execute core
`ifndef CEX_CONSTS_SVH
`define CEX_CONSTS_SVH

// File register indices; the bus byte address is four times the index
`define CEX_IDX_IPH      6'h04
`define CEX_IDX_IPL      6'h05
`define CEX_IDX_SPH      6'h06
`define CEX_IDX_SPL      6'h07
`define CEX_IDX_PCH      6'h08
`define CEX_IDX_PCL      6'h09
`define CEX_IDX_ACC      6'h0A
`define CEX_IDX_STATUS   6'h0B
`define CEX_IDX_DPH      6'h0C
`define CEX_IDX_DPL      6'h0D
`define CEX_IDX_RATE     6'h0E
`define CEX_IDX_PRODH    6'h0F
`define CEX_IDX_PMADRH   6'h10
`define CEX_IDX_PMADRL   6'h11
`define CEX_IDX_PMDATH   6'h12
`define CEX_IDX_PMDATL   6'h13
`define CEX_IDX_PBFLAG   6'h17
`define CEX_IDX_PBEDGE   6'h19
`define CEX_IDX_EXTENDED_CONFIG     6'h1C
`define CEX_IDX_RSVD_1D  6'h1D
`define CEX_IDX_IRETH    6'h1E
`define CEX_IDX_IRETL    6'h1F
`define CEX_IDX_PORTA_PIN_STATE     6'h20
`define CEX_IDX_PORTA_OUT_LATCH    6'h21
`define CEX_IDX_PORTA_DIRECTION    6'h22
`define CEX_IDX_RSVD_23  6'h23
`define CEX_IDX_PORTB_PIN_STATE     6'h24
`define CEX_IDX_FIRST    6'h04
`define CEX_IDX_LAST     6'h24
`define CEX_IDX_SPAN     37

// Status register field positions and the address bits that feed the page field
`define CEX_ST_CARRY     0
`define CEX_ST_NIBBLE    1
`define CEX_ST_NULL      2
`define CEX_ST_PAGE_HI   7
`define CEX_ST_PAGE_LO   5
`define CEX_PAGE_ADR_HI  15
`define CEX_PAGE_ADR_LO  13

// Reset values
`define CEX_RST_ZERO     8'h00
`define CEX_RST_ONES     8'hFF
`define CEX_RST_PC       16'hFFF0
`define CEX_RST_ST_POR   8'hE0
`define CEX_RST_ST_BOR   8'hE8
`define CEX_RST_ST_WDT   8'hF0
`define CEX_RST_RATE     8'h93
`define CEX_RST_EXTENDED_CONFIG     8'h01

// Stack storage depth index width
`define CEX_STK_AW       4

`endif

// >>> inc/cex_pkg.sv
// Types shared by the execute core and its users
package cex_pkg;

  // Instruction classes handled by the execute core
  typedef enum logic [4:0] {
    CEX_OP_NOP      = 5'h00,
    CEX_OP_RL       = 5'h01,
    CEX_OP_RR       = 5'h02,
    CEX_OP_SUB      = 5'h03,
    CEX_OP_SUB_LIT  = 5'h04,
    CEX_OP_SUBC     = 5'h05,
    CEX_OP_SWAP     = 5'h06,
    CEX_OP_TEST     = 5'h07,
    CEX_OP_CLRB     = 5'h08,
    CEX_OP_SETB     = 5'h09,
    CEX_OP_SB       = 5'h0A,
    CEX_OP_SNB      = 5'h0B,
    CEX_OP_PUSH     = 5'h0C,
    CEX_OP_PUSH_LIT = 5'h0D,
    CEX_OP_POP      = 5'h0E,
    CEX_OP_RET      = 5'h0F,
    CEX_OP_RETW     = 5'h10,
    CEX_OP_PAGE     = 5'h11,
    CEX_OP_LOADH    = 5'h12,
    CEX_OP_SPEED    = 5'h13,
    CEX_OP_FERASE   = 5'h14,
    CEX_OP_FREAD    = 5'h15,
    CEX_OP_FWRITE   = 5'h16,
    CEX_OP_IREAD    = 5'h17,
    CEX_OP_IWRITE   = 5'h18
  } cex_op_t;

  // Cause of the last reset, selects the status reset pattern
  typedef enum logic [1:0] {
    CEX_RST_POR  = 2'h0,
    CEX_RST_BOR  = 2'h1,
    CEX_RST_WDOG = 2'h2
  } cex_rst_cause_t;

endpackage : cex_pkg

// >>> verilog/cex_core.sv
// Execute datapath and special-function register map of the 8-bit core
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "cex_consts.svh"

module cex_core (
  // Clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire cex_pkg::cex_rst_cause_t rst_cause_i,
  // Instruction issue
  input  wire logic                   op_valid_i,
  output logic                        op_ready_o,
  input  wire cex_pkg::cex_op_t       op_code_i,
  input  wire logic [5:0]             op_file_i,
  input  wire logic [2:0]             op_bit_i,
  input  wire logic                   op_dest_w_i,
  input  wire logic [7:0]             op_imm_i,
  input  wire logic [15:0]            op_addr_i,
  output logic                        skip_pend_o,
  output logic [15:0]                 pc_o,
  output logic [7:0]                  rate_o,
  // Program memory and flash strobes
  output logic                        flash_erase_o,
  output logic                        flash_read_o,
  output logic                        flash_write_o,
  output logic                        pm_read_o,
  output logic                        pm_write_o,
  output logic [15:0]                 pm_addr_o,
  output logic [15:0]                 pm_wdata_o,
  input  wire logic                   pm_rvalid_i,
  input  wire logic [15:0]            pm_rdata_i,
  // Port pins
  input  wire logic [7:0]             porta_pins_i,
  input  wire logic [7:0]             portb_pins_i,
  output logic [7:0]                  porta_out_o,
  output logic [7:0]                  porta_oe_n_o,
  // Wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o
);
  import cex_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]  sfr [`CEX_IDX_SPAN];
  logic [7:0]  stk [2**`CEX_STK_AW];
  logic [15:0] pc;
  logic        skip_pend;
  logic [7:0]  pa_meta, pa_sync, pb_meta, pb_sync;

  // Combinational results
  logic [7:0]  fop, next_res;
  logic        next_c, next_dc, next_z;
  logic        wr_f, wr_w, upd_c, upd_dc, upd_z, skip_now;
  logic        op_take, op_exec, wb_req, wb_commit;
  logic [5:0]  wb_idx;
  logic [15:0] sp, sp_dec, sp_inc;

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  // Subtract with borrow-in; carry and nibble flag mean no borrow out
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                      input logic bin);
    logic [8:0] full;
    logic [4:0] nib;
    full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    sub8 = {~full[8], ~nib[4], full[7:0]};
  endfunction : sub8

  // Reset image of each map location other than status and the program counter bytes
  function automatic logic [7:0] rst_val(input int idx);
    unique case (idx)
      `CEX_IDX_RATE:  rst_val = `CEX_RST_RATE;
      `CEX_IDX_EXTENDED_CONFIG:  rst_val = `CEX_RST_EXTENDED_CONFIG;
      `CEX_IDX_PORTA_DIRECTION: rst_val = `CEX_RST_ONES;
      default:        rst_val = `CEX_RST_ZERO;
    endcase
  endfunction : rst_val

  // File read: live views for counter and pins, zero for reserved holes
  function automatic logic [7:0] file_rd(input logic [5:0] idx);
    if (idx < `CEX_IDX_FIRST || idx > `CEX_IDX_LAST ||
        idx == `CEX_IDX_RSVD_1D || idx == `CEX_IDX_RSVD_23) begin
      file_rd = 8'h00;
    end else if (idx == `CEX_IDX_PCH) begin
      file_rd = pc[15:8];
    end else if (idx == `CEX_IDX_PCL) begin
      file_rd = pc[7:0];
    end else if (idx == `CEX_IDX_PORTA_PIN_STATE) begin
      file_rd = pa_sync;
    end else if (idx == `CEX_IDX_PORTB_PIN_STATE) begin
      file_rd = pb_sync;
    end else begin
      file_rd = sfr[idx];
    end
  endfunction : file_rd

  // Locations that ignore writes
  function automatic logic file_ro(input logic [5:0] idx);
    file_ro = (idx < `CEX_IDX_FIRST) || (idx > `CEX_IDX_LAST) ||
              (idx == `CEX_IDX_PCH) || (idx == `CEX_IDX_RATE) ||
              (idx == `CEX_IDX_PORTA_PIN_STATE) || (idx == `CEX_IDX_PORTB_PIN_STATE) ||
              (idx == `CEX_IDX_RSVD_1D) || (idx == `CEX_IDX_RSVD_23);
  endfunction : file_ro

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pa_meta <= porta_pins_i;
      pa_sync <= pa_meta;
      pb_meta <= portb_pins_i;
      pb_sync <= pb_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Handshake decode; a committing bus write owns the cycle, so issue stalls
  assign wb_req     = wb_cyc_i & wb_stb_i;
  assign wb_idx     = wb_adr_i[7:2];
  assign wb_commit  = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0] & ce_i;
  assign op_ready_o = ~(wb_req & wb_ack_o & wb_we_i);
  assign op_take    = op_valid_i & op_ready_o & ce_i;
  assign op_exec    = op_take & ~skip_pend;
  assign sp         = {sfr[`CEX_IDX_SPH], sfr[`CEX_IDX_SPL]};
  assign sp_dec     = sp - 16'h0001;
  assign sp_inc     = sp + 16'h0001;
  // Process form, so the operand follows register updates and not only index changes
  always_comb fop = file_rd(op_file_i);

  //////////////////////////////////////////////////////////////////////////////
  // ALU: result, destination and flag updates of the current instruction
  always_comb begin
    next_res = fop;
    next_c   = sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY];
    next_dc  = sfr[`CEX_IDX_STATUS][`CEX_ST_NIBBLE];
    next_z   = sfr[`CEX_IDX_STATUS][`CEX_ST_NULL];
    wr_f     = 1'b0;
    wr_w     = 1'b0;
    upd_c    = 1'b0;
    upd_dc   = 1'b0;
    upd_z    = 1'b0;
    skip_now = 1'b0;
    unique case (op_code_i)
      CEX_OP_RL: begin
        {next_c, next_res} = {fop, sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY]};
        upd_c = 1'b1;
        wr_w  = op_dest_w_i;
        wr_f  = ~op_dest_w_i;
      end
      CEX_OP_RR: begin
        {next_res, next_c} = {sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY], fop};
        upd_c = 1'b1;
        wr_w  = op_dest_w_i;
        wr_f  = ~op_dest_w_i;
      end
      CEX_OP_SUB: begin
        {next_c, next_dc, next_res} = sub8(fop, sfr[`CEX_IDX_ACC], 1'b0);
        {upd_c, upd_dc, upd_z} = 3'b111;
        wr_w  = op_dest_w_i;
        wr_f  = ~op_dest_w_i;
      end
      CEX_OP_SUB_LIT: begin
        {next_c, next_dc, next_res} = sub8(op_imm_i, sfr[`CEX_IDX_ACC], 1'b0);
        {upd_c, upd_dc, upd_z} = 3'b111;
        wr_w  = 1'b1;
      end
      CEX_OP_SUBC: begin
        {next_c, next_dc, next_res} = sub8(fop, sfr[`CEX_IDX_ACC],
                                           ~sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY]);
        {upd_c, upd_dc, upd_z} = 3'b111;
        wr_w  = op_dest_w_i;
        wr_f  = ~op_dest_w_i;
      end
      CEX_OP_SWAP: begin
        next_res = {fop[3:0], fop[7:4]};
        wr_w     = op_dest_w_i;
        wr_f     = ~op_dest_w_i;
      end
      CEX_OP_TEST: begin
        upd_z = 1'b1;
      end
      CEX_OP_CLRB: begin
        next_res = fop & ~(8'h01 << op_bit_i);
        wr_f     = 1'b1;
      end
      CEX_OP_SETB: begin
        next_res = fop | (8'h01 << op_bit_i);
        wr_f     = 1'b1;
      end
      CEX_OP_SB:  skip_now = fop[op_bit_i];
      CEX_OP_SNB: skip_now = ~fop[op_bit_i];
      default: begin
        next_res = fop;
      end
    endcase
    // Null flag follows the produced byte; zero check looks at the operand
    if (upd_z) begin
      next_z = (next_res == 8'h00);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Skip tracker: one pending skip swallows exactly the next issued op
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_pend <= 1'b0;
    end else if (op_take) begin
      skip_pend <= op_exec & skip_now;
    end
  end
  assign skip_pend_o = skip_pend;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, program counter and stack storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CEX_IDX_SPAN; i++) begin
        sfr[i] <= rst_val(i);
      end
      // Status pattern depends on what caused the reset
      unique case (rst_cause_i)
        CEX_RST_BOR:  sfr[`CEX_IDX_STATUS] <= `CEX_RST_ST_BOR;
        CEX_RST_WDOG: sfr[`CEX_IDX_STATUS] <= `CEX_RST_ST_WDT;
        default:      sfr[`CEX_IDX_STATUS] <= `CEX_RST_ST_POR;
      endcase
      pc <= `CEX_RST_PC;
    end else if (ce_i) begin
      // Bus write; read-only holes silently drop the data
      if (wb_commit && !file_ro(wb_idx)) begin
        if (wb_idx == `CEX_IDX_PCL) begin
          pc[7:0] <= wb_dat_i[7:0];
        end else begin
          sfr[wb_idx] <= wb_dat_i[7:0];
        end
      end
      // Returned program-memory word lands in the data byte pair
      if (pm_rvalid_i) begin
        sfr[`CEX_IDX_PMDATH] <= pm_rdata_i[15:8];
        sfr[`CEX_IDX_PMDATL] <= pm_rdata_i[7:0];
      end
      if (op_exec) begin
        if (wr_f && !file_ro(op_file_i)) begin
          if (op_file_i == `CEX_IDX_PCL) begin
            pc[7:0] <= next_res;
          end else begin
            sfr[op_file_i] <= next_res;
          end
        end
        if (wr_w) begin
          sfr[`CEX_IDX_ACC] <= next_res;
        end
        // Flag writes come last so they win over a result aimed at status
        if (upd_c) begin
          sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY] <= next_c;
        end
        if (upd_dc) begin
          sfr[`CEX_IDX_STATUS][`CEX_ST_NIBBLE] <= next_dc;
        end
        if (upd_z) begin
          sfr[`CEX_IDX_STATUS][`CEX_ST_NULL] <= next_z;
        end
        unique case (op_code_i)
          CEX_OP_PUSH, CEX_OP_PUSH_LIT: begin
            stk[sp[`CEX_STK_AW-1:0]] <= (op_code_i == CEX_OP_PUSH) ? fop : op_imm_i;
            {sfr[`CEX_IDX_SPH], sfr[`CEX_IDX_SPL]} <= sp_dec;
          end
          CEX_OP_POP: begin
            {sfr[`CEX_IDX_SPH], sfr[`CEX_IDX_SPL]} <= sp_inc;
            if (!file_ro(op_file_i) && op_file_i != `CEX_IDX_PCL) begin
              sfr[op_file_i] <= stk[sp_inc[`CEX_STK_AW-1:0]];
            end
          end
          CEX_OP_RET, CEX_OP_RETW: begin
            pc <= op_addr_i;
            sfr[`CEX_IDX_STATUS][`CEX_ST_PAGE_HI:`CEX_ST_PAGE_LO] <=
              op_addr_i[`CEX_PAGE_ADR_HI:`CEX_PAGE_ADR_LO];
            if (op_code_i == CEX_OP_RETW) begin
              sfr[`CEX_IDX_ACC] <= op_imm_i;
            end
          end
          CEX_OP_PAGE: begin
            sfr[`CEX_IDX_STATUS][`CEX_ST_PAGE_HI:`CEX_ST_PAGE_LO] <=
              op_addr_i[`CEX_PAGE_ADR_HI:`CEX_PAGE_ADR_LO];
          end
          CEX_OP_LOADH: sfr[`CEX_IDX_DPH]  <= op_addr_i[15:8];
          CEX_OP_SPEED: sfr[`CEX_IDX_RATE] <= op_imm_i;
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory strobes: one-cycle pulses, address and data from the byte registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {flash_erase_o, flash_read_o, flash_write_o, pm_read_o, pm_write_o} <= 5'h00;
    end else if (ce_i) begin
      flash_erase_o <= op_exec && (op_code_i == CEX_OP_FERASE);
      flash_read_o  <= op_exec && (op_code_i == CEX_OP_FREAD);
      flash_write_o <= op_exec && (op_code_i == CEX_OP_FWRITE);
      pm_read_o     <= op_exec && (op_code_i == CEX_OP_IREAD);
      pm_write_o    <= op_exec && (op_code_i == CEX_OP_IWRITE);
    end
  end
  assign pm_addr_o    = {sfr[`CEX_IDX_PMADRH], sfr[`CEX_IDX_PMADRL]};
  assign pm_wdata_o   = {sfr[`CEX_IDX_PMDATH], sfr[`CEX_IDX_PMDATL]};
  assign pc_o         = pc;
  assign rate_o       = sfr[`CEX_IDX_RATE];
  assign porta_out_o  = sfr[`CEX_IDX_PORTA_OUT_LATCH];
  // Direction bit one means input, so it doubles as the active-low enable
  assign porta_oe_n_o = sfr[`CEX_IDX_PORTA_DIRECTION];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: ack one cycle after the request, then drop for a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, file_rd(wb_idx)};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_push;
    op_exec && (op_code_i == CEX_OP_PUSH || op_code_i == CEX_OP_PUSH_LIT) && !wb_commit;
  endsequence
  sequence s_pop;
    op_exec && op_code_i == CEX_OP_POP && op_file_i != `CEX_IDX_SPH &&
    op_file_i != `CEX_IDX_SPL && !wb_commit;
  endsequence

  a_push_sp_dec: assert property (@(posedge clk_i) disable iff (rst_i)
    s_push |=> sp == $past(sp) - 16'h0001)
    else $error("push did not decrement stack pointer");
  a_pop_sp_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pop |=> sp == $past(sp) + 16'h0001)
    else $error("pop did not increment stack pointer");
  a_skip_one_op: assert property (@(posedge clk_i) disable iff (rst_i)
    op_take && skip_pend |=> !skip_pend && $stable(sfr[`CEX_IDX_ACC]) && $stable(pc))
    else $error("skipped op changed state");
  a_skip_set_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    op_exec && op_code_i == CEX_OP_SB |=> skip_pend == $past(fop[op_bit_i]))
    else $error("skip on set bit wrong");
  a_test_null: assert property (@(posedge clk_i) disable iff (rst_i)
    op_exec && op_code_i == CEX_OP_TEST && !wb_commit
    |=> sfr[`CEX_IDX_STATUS][`CEX_ST_NULL] == ($past(fop) == 8'h00))
    else $error("zero check flag wrong");
  a_swap_to_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    op_exec && op_code_i == CEX_OP_SWAP && op_dest_w_i && !wb_commit
    |=> sfr[`CEX_IDX_ACC] == {$past(fop[3:0]), $past(fop[7:4])} &&
        $stable(sfr[`CEX_IDX_STATUS]))
    else $error("nibble exchange wrong");
  a_rotate_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    op_exec && op_code_i == CEX_OP_RL && op_dest_w_i && !wb_commit
    |=> sfr[`CEX_IDX_STATUS][`CEX_ST_CARRY] == $past(fop[7]) &&
        sfr[`CEX_IDX_STATUS][7:1] == $past(sfr[`CEX_IDX_STATUS][7:1]))
    else $error("rotate flags wrong");
  a_page_load: assert property (@(posedge clk_i) disable iff (rst_i)
    op_exec && op_code_i == CEX_OP_PAGE && !wb_commit
    |=> sfr[`CEX_IDX_STATUS][7:5] == $past(op_addr_i[15:13]) &&
        sfr[`CEX_IDX_STATUS][4:0] == $past(sfr[`CEX_IDX_STATUS][4:0]))
    else $error("page load wrong");
  a_pch_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_commit && wb_idx == `CEX_IDX_PCH && !op_take |=> $stable(pc))
    else $error("program counter high written");
  a_ack_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule : cex_core

// >>> test/cex_core_bench.sv
// Self-checking bench for the execute core and its register map
`timescale 1ns/1ps
`include "cex_consts.svh"

module cex_core_bench;
  import cex_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observed outputs
  logic        clk_i, rst_i, cyc, stb, we, vld, dw, wb_ack_o, skip_pend_o, op_ready_o;
  logic [7:0]  imm, rd, porta_oe_n_o, porta_out_o;
  logic [5:0]  fil;
  logic [2:0]  bsel;
  logic [15:0] oad;
  logic [31:0] wdat, wb_dat_o;
  logic [7:0]  adr;
  cex_op_t     code;
  cex_rst_cause_t cause;
  logic        ce, pmv;
  logic [15:0] pmd, pc_o, pm_addr_o, pm_wdata_o;
  logic [7:0]  rate_o;
  wire  [4:0]  strb;
  int          miscompares, checked;
  // Index and reset value pairs of the map
  localparam logic [15:0] RV [14] = '{16'h0600, 16'h0700, 16'h08FF, 16'h09F0, 16'h0A00,
    16'h0BE0, 16'h0E93, 16'h0F00, 16'h1700, 16'h1900, 16'h1C01, 16'h1F00, 16'h2100, 16'h22FF};

  // Design under test; strobes gathered as {erase, fread, fwrite, pm read, pm write}
  cex_core cex_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .rst_cause_i(cause),
    .op_valid_i(vld), .op_ready_o(op_ready_o), .op_code_i(code), .op_file_i(fil),
    .op_bit_i(bsel), .op_dest_w_i(dw), .op_imm_i(imm), .op_addr_i(oad),
    .skip_pend_o(skip_pend_o), .pc_o(pc_o), .rate_o(rate_o), .flash_erase_o(strb[4]),
    .flash_read_o(strb[3]), .flash_write_o(strb[2]), .pm_read_o(strb[1]),
    .pm_write_o(strb[0]), .pm_addr_o(pm_addr_o), .pm_wdata_o(pm_wdata_o),
    .pm_rvalid_i(pmv), .pm_rdata_i(pmd), .porta_pins_i(8'h3C), .portb_pins_i(8'hA5),
    .porta_out_o(porta_out_o), .porta_oe_n_o(porta_oe_n_o), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; holds everything until ack is sampled high
  task wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16) miscompares++;
    rd = wb_dat_o[7:0];
    if (w) chk({7'h00, op_ready_o}, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task rc(input logic [5:0] i, input logic [7:0] exp);
    wb(1'b0, i, 8'h00);
    chk(rd, exp);
  endtask : rc

  // Offer one instruction for one edge, then withdraw it
  task op(input cex_op_t c, input logic [5:0] f, input logic [2:0] b, input logic d,
          input logic [7:0] i, input logic [15:0] a);
    @(posedge clk_i);
    vld  <= 1'b1;
    code <= c;
    fil  <= f;
    bsel <= b;
    dw   <= d;
    imm  <= i;
    oad  <= a;
    @(posedge clk_i);
    vld <= 1'b0;
  endtask : op

  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_map;
    for (int k = 0; k < 14; k++) rc(RV[k][13:8], RV[k][7:0]);
    chk(porta_oe_n_o, 8'hFF);
    wb(1'b1, 6'h08, 8'h12);
    rc(6'h08, 8'hFF);
    rc(6'h30, 8'h00);
    wb(1'b1, 6'h21, 8'h69);
    rc(6'h21, 8'h69);
    chk(porta_out_o, 8'h69);
    rc(6'h20, 8'h3C);
    $display("map test done");
  endtask : t_map

  // Subtract forms, exchange, zero check and rotate with flag effects
  task t_alu;
    wb(1'b1, 6'h0A, 8'h05);
    wb(1'b1, 6'h0F, 8'h03);
    op(CEX_OP_SUB, 6'h0F, 3'h0, 1'b0, 8'h00, 16'h0000);
    rc(6'h0F, 8'hFE);
    rc(6'h0B, 8'hE0);
    op(CEX_OP_SUB_LIT, 6'h00, 3'h0, 1'b1, 8'h05, 16'h0000);
    rc(6'h0A, 8'h00);
    rc(6'h0B, 8'hE7);
    op(CEX_OP_SUBC, 6'h0F, 3'h0, 1'b1, 8'h00, 16'h0000);
    rc(6'h0A, 8'hFE);
    rc(6'h0B, 8'hE3);
    op(CEX_OP_SWAP, 6'h0F, 3'h0, 1'b1, 8'h00, 16'h0000);
    rc(6'h0A, 8'hEF);
    op(CEX_OP_TEST, 6'h1F, 3'h0, 1'b0, 8'h00, 16'h0000);
    rc(6'h0B, 8'hE7);
    op(CEX_OP_RL, 6'h0F, 3'h0, 1'b0, 8'h00, 16'h0000);
    rc(6'h0F, 8'hFD);
    rc(6'h0B, 8'hE7);
    $display("alu test done");
  endtask : t_alu

  // A met skip must swallow exactly the next instruction
  task t_skip;
    op(CEX_OP_SB, 6'h0F, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({7'h00, skip_pend_o}, 8'h01);
    op(CEX_OP_SETB, 6'h0F, 3'h1, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({7'h00, skip_pend_o}, 8'h00);
    op(CEX_OP_SNB, 6'h0F, 3'h1, 1'b0, 8'h00, 16'h0000);
    op(CEX_OP_CLRB, 6'h0F, 3'h0, 1'b0, 8'h00, 16'h0000);
    op(CEX_OP_SETB, 6'h0F, 3'h1, 1'b0, 8'h00, 16'h0000);
    rc(6'h0F, 8'hFF);
    rc(6'h0B, 8'hE7);
    $display("skip test done");
  endtask : t_skip

  // Stack moves, page loads, returns and the flash erase strobe
  task t_flow;
    op(CEX_OP_PUSH_LIT, 6'h00, 3'h0, 1'b0, 8'h5A, 16'h0000);
    rc(6'h07, 8'hFF);
    rc(6'h06, 8'hFF);
    op(CEX_OP_POP, 6'h13, 3'h0, 1'b0, 8'h00, 16'h0000);
    rc(6'h13, 8'h5A);
    rc(6'h07, 8'h00);
    op(CEX_OP_PAGE, 6'h00, 3'h0, 1'b0, 8'h00, 16'h4000);
    rc(6'h0B, 8'h47);
    op(CEX_OP_RETW, 6'h00, 3'h0, 1'b0, 8'h33, 16'h2000);
    rc(6'h0A, 8'h33);
    rc(6'h0B, 8'h27);
    op(CEX_OP_FERASE, 6'h00, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h10);
    rc(6'h0B, 8'h27);
    $display("flow test done");
  endtask : t_flow

  // Rotate right, file push, data high load, clock enable, memory strobes, reset cause
  task t_misc;
    op(CEX_OP_RR, 6'h1F, 3'h0, 1'b1, 8'h00, 16'h0000);
    rc(6'h0A, 8'h80);
    rc(6'h0B, 8'h26);
    op(CEX_OP_RL, 6'h0F, 3'h0, 1'b1, 8'h00, 16'h0000);
    rc(6'h0A, 8'hFE);
    rc(6'h0B, 8'h27);
    op(CEX_OP_PUSH, 6'h0F, 3'h0, 1'b0, 8'h00, 16'h0000);
    op(CEX_OP_POP, 6'h1C, 3'h0, 1'b0, 8'h00, 16'h0000);
    rc(6'h1C, 8'hFF);
    rc(6'h07, 8'h00);
    op(CEX_OP_LOADH, 6'h00, 3'h0, 1'b0, 8'h00, 16'hAB00);
    rc(6'h0C, 8'hAB);
    // An op offered while the enable is low must leave no trace
    @(posedge clk_i);
    ce <= 1'b0;
    op(CEX_OP_SPEED, 6'h00, 3'h0, 1'b0, 8'h41, 16'h0000);
    ce <= 1'b1;
    @(negedge clk_i);
    chk(rate_o, 8'h93);
    op(CEX_OP_SPEED, 6'h00, 3'h0, 1'b0, 8'h41, 16'h0000);
    @(negedge clk_i);
    chk(rate_o, 8'h41);
    wb(1'b1, 6'h10, 8'h12);
    wb(1'b1, 6'h11, 8'h34);
    op(CEX_OP_IREAD, 6'h00, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h02);
    chk(pm_addr_o[15:8], 8'h12);
    chk(pm_addr_o[7:0], 8'h34);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h00);
    @(posedge clk_i);
    pmv <= 1'b1;
    pmd <= 16'hC3A5;
    @(posedge clk_i);
    pmv <= 1'b0;
    rc(6'h12, 8'hC3);
    chk(pm_wdata_o[7:0], 8'hA5);
    op(CEX_OP_IWRITE, 6'h00, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h01);
    op(CEX_OP_FREAD, 6'h00, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h08);
    op(CEX_OP_FWRITE, 6'h00, 3'h0, 1'b0, 8'h00, 16'h0000);
    @(negedge clk_i);
    chk({3'h0, strb}, 8'h04);
    // Second reset in mid-run, caused by brown-out
    @(posedge clk_i);
    rst_i <= 1'b1;
    cause <= CEX_RST_BOR;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(6'h0B, 8'hE8);
    chk(pc_o[15:8], 8'hFF);
    chk(rate_o, 8'h93);
    wb(1'b1, 6'h09, 8'h5A);
    @(negedge clk_i);
    chk(pc_o[7:0], 8'h5A);
    $display("misc test done");
  endtask : t_misc

  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    stop_test;
  end

  initial begin
    {rst_i, cyc, stb, we, vld, dw} = 6'b100000;
    {imm, fil, bsel, oad, wdat, adr} = '0;
    code = CEX_OP_NOP;
    cause = CEX_RST_POR;
    ce = 1'b1;
    pmv = 1'b0;
    pmd = 16'h0000;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_map;
    t_alu;
    t_skip;
    t_flow;
    t_misc;
    stop_test;
  end
endmodule : cex_core_bench
